// *** common/jsf_pkg.sv ***
// constants for the encoder status and fifo monitor register bank
// assumes one clock, word-indexed registers on a 32-bit wishbone bus
// Functional notes
// R1: watermark field at bits 5:4 codes fifo fill quarters 00 to 11.
// R2: writing one to bit 4 of main status clears the watermark.
// R3: bits 7:6 report quantization set 0..2; code 11 never appears.
// R4: main status bits 15:8 show length count bits 23:16.
// R5: separate read-only register shows length bits 15:0 of the 24-bit count.
// R6: on output fifo overflow the length count freezes at bytes already sent.
// R7: fullness code 000 empty, 001, 011, 010, 110 by fill quarter.
// R8: front-end config register bit 0 selects composition, zero means 4:2:2.
// R9: fullness code refreshed every cycle and only legal codes appear.
package jsf_pkg;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_STATUS_MAIN  = 6'h02;
  localparam logic [5:0] IDX_LEN_LOW      = 6'h03;
  localparam logic [5:0] IDX_FULLNESS     = 6'h04;
  localparam logic [5:0] IDX_FRONT_CFG    = 6'h05;
  localparam logic [5:0] IDX_IRQ_STATUS   = 6'h08;
  localparam logic [5:0] IDX_IRQ_MASK     = 6'h09;

  // field positions in main status
  localparam int WM_LSB     = 4;
  localparam int QSET_LSB   = 6;
  localparam int LENHI_LSB  = 8;
  localparam int WM_CLR_BIT = 4;

  // widths
  localparam int LEN_W = 24;
  localparam int CFG_W = 6;
  localparam int IRQ_W = 2;

  // interrupt status bit positions
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_WM_BIT  = 1;

  // values after reset, and the length count limit
  localparam logic [LEN_W-1:0] LEN_RST  = 24'h000000;
  localparam logic [CFG_W-1:0] CFG_RST  = 6'h00;
  localparam logic [1:0]       WM_RST   = 2'h0;
  localparam logic [1:0]       QSET_RST = 2'h0;
  localparam logic [2:0]       FULL_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 2'h0;
  localparam logic [LEN_W-1:0] LEN_MAX  = 24'hFFFFFF;

  // quantization set code left reserved
  localparam logic [1:0] QSET_RSVD = 2'h3;

  // fullness codes
  localparam logic [2:0] FULL_EMPTY = 3'h0;
  localparam logic [2:0] FULL_Q0    = 3'h1;
  localparam logic [2:0] FULL_Q1    = 3'h3;
  localparam logic [2:0] FULL_Q2    = 3'h2;
  localparam logic [2:0] FULL_Q3    = 3'h6;

  // watermark codes
  localparam logic [1:0] WM_TOP = 2'h3;

endpackage

// *** design/jsf_monitor.sv ***
// status, fifo monitor and front-end config registers of the jpeg encoder
// assumes encoder and fifo strobes are on clk; wishbone classic slave
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module jsf_monitor #(
  parameter int DEPTH = 1024
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // wishbone classic slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // encoder and fifo side
  input  wire logic [$clog2(DEPTH+1)-1:0] fifo_level,
  input  wire logic                    fifo_overflow,
  input  wire logic                    byte_sent,
  input  wire logic                    frame_start,
  input  wire logic [1:0]              quant_set_select,
  // configuration and interrupt
  output logic [jsf_pkg::CFG_W-1:0]    front_end_config,
  output logic                         irq
);

  localparam int LVL_W = $clog2(DEPTH+1);
  localparam int CMP_W = LVL_W + 3;
  localparam logic [CMP_W-1:0] TH1 = CMP_W'(DEPTH);
  localparam logic [CMP_W-1:0] TH2 = CMP_W'(2 * DEPTH);
  localparam logic [CMP_W-1:0] TH3 = CMP_W'(3 * DEPTH);

  // state
  logic [1:0]                  wm;
  logic [1:0]                  qset;
  logic [jsf_pkg::LEN_W-1:0]   len;
  logic                        frozen;
  logic [2:0]                  full_code;
  logic [jsf_pkg::IRQ_W-1:0]   irq_status;
  logic [jsf_pkg::IRQ_W-1:0]   irq_mask;

  // next values
  logic [1:0]                  next_wm;
  logic [1:0]                  next_qset;
  logic [jsf_pkg::LEN_W-1:0]   next_len;
  logic                        next_frozen;
  logic [2:0]                  next_full_code;
  logic [jsf_pkg::IRQ_W-1:0]   next_irq_status;
  logic [jsf_pkg::IRQ_W-1:0]   next_irq_mask;
  logic [jsf_pkg::CFG_W-1:0]   next_front_end_config;
  logic                        next_irq;
  logic [31:0]                 next_dat;
  logic                        next_ack;

  // decoded bus terms
  logic [5:0]                  idx;
  logic                        req;
  logic                        wr_now;
  logic                        rd_now;
  logic                        wm_clr;
  logic [1:0]                  cur_q;
  logic [CMP_W-1:0]            lvl4;

  // bus decode, a write lands on the edge that sees ack, a read clears where its data is captured
  assign idx    = wb_adr_i[7:2];
  assign req    = wb_cyc_i & wb_stb_i;
  assign wr_now = req & wb_we_i & wb_ack_o;
  assign rd_now = req & ~wb_we_i & ~wb_ack_o; // clearing later would drop an event caught after the capture
  assign wm_clr = wr_now & wb_sel_i[0] & (idx == jsf_pkg::IDX_STATUS_MAIN)
                  & wb_dat_i[jsf_pkg::WM_CLR_BIT];
  assign lvl4   = CMP_W'({fifo_level, 2'b00});

  // fill quarter of the fifo right now
  always_comb begin
    if (lvl4 < TH1) begin
      cur_q = 2'h0;
    end else if (lvl4 < TH2) begin
      cur_q = 2'h1;
    end else if (lvl4 < TH3) begin
      cur_q = 2'h2;
    end else begin
      cur_q = 2'h3;
    end
  end

  // fullness code from occupancy, refreshed each cycle
  always_comb begin
    if (fifo_level == '0) begin
      next_full_code = jsf_pkg::FULL_EMPTY; // see R7
    end else begin
      unique case (cur_q)
        2'h0: next_full_code = jsf_pkg::FULL_Q0; // see R7
        2'h1: next_full_code = jsf_pkg::FULL_Q1; // see R7
        2'h2: next_full_code = jsf_pkg::FULL_Q2; // see R7
        2'h3: next_full_code = jsf_pkg::FULL_Q3; // see R7
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      full_code <= jsf_pkg::FULL_RST;
    end else begin
      full_code <= next_full_code; // see R9
    end
  end

  // watermark keeps the highest quarter reached, and quant set
  always_comb begin
    if (wm_clr) begin
      next_wm = cur_q; // see R2
    end else if (cur_q > wm) begin
      next_wm = cur_q; // see R1
    end else begin
      next_wm = wm;
    end
    if (quant_set_select == jsf_pkg::QSET_RSVD) begin
      next_qset = qset; // see R3
    end else begin
      next_qset = quant_set_select; // see R3
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wm   <= jsf_pkg::WM_RST;
      qset <= jsf_pkg::QSET_RST;
    end else begin
      wm   <= next_wm;
      qset <= next_qset;
    end
  end

  // length count, frozen by overflow until next frame
  always_comb begin
    next_len    = len;
    next_frozen = frozen;
    if (frame_start) begin
      next_len    = jsf_pkg::LEN_RST;
      next_frozen = 1'b0;
    end else if (fifo_overflow) begin
      next_frozen = 1'b1; // see R6
    end else if (byte_sent && !frozen && len != jsf_pkg::LEN_MAX) begin
      next_len = len + 24'h000001; // see R5
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      len    <= jsf_pkg::LEN_RST;
      frozen <= 1'b0;
    end else begin
      len    <= next_len;
      frozen <= next_frozen;
    end
  end

  // config, mask and sticky interrupt status; set wins over read clear
  always_comb begin
    next_front_end_config = front_end_config;
    next_irq_mask         = irq_mask;
    next_irq_status       = irq_status;
    if (wr_now && wb_sel_i[0] && idx == jsf_pkg::IDX_FRONT_CFG) begin
      next_front_end_config = wb_dat_i[jsf_pkg::CFG_W-1:0]; // see R8
    end
    if (wr_now && wb_sel_i[0] && idx == jsf_pkg::IDX_IRQ_MASK) begin
      next_irq_mask = wb_dat_i[jsf_pkg::IRQ_W-1:0];
    end
    if (rd_now && idx == jsf_pkg::IDX_IRQ_STATUS) begin
      next_irq_status = '0;
    end
    if (fifo_overflow && !frozen) begin
      next_irq_status[jsf_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (next_wm == jsf_pkg::WM_TOP && wm != jsf_pkg::WM_TOP) begin
      next_irq_status[jsf_pkg::IRQ_WM_BIT] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      front_end_config <= jsf_pkg::CFG_RST;
      irq_mask         <= jsf_pkg::IRQ_RST;
      irq_status       <= jsf_pkg::IRQ_RST;
      irq              <= 1'b0;
    end else begin
      front_end_config <= next_front_end_config;
      irq_mask         <= next_irq_mask;
      irq_status       <= next_irq_status;
      irq              <= next_irq;
    end
  end

  // read mux, data captured with ack, unmapped reads zero
  always_comb begin
    next_ack = req & ~wb_ack_o;
    next_dat = 32'h00000000;
    if (next_ack && !wb_we_i) begin
      unique case (idx)
        jsf_pkg::IDX_STATUS_MAIN: begin
          next_dat[jsf_pkg::WM_LSB +: 2]    = wm; // see R1
          next_dat[jsf_pkg::QSET_LSB +: 2]  = qset; // see R3
          next_dat[jsf_pkg::LENHI_LSB +: 8] = len[23:16]; // see R4
        end
        jsf_pkg::IDX_LEN_LOW: begin
          next_dat[15:0] = len[15:0]; // see R5
        end
        jsf_pkg::IDX_FULLNESS: begin
          next_dat[2:0] = full_code; // see R7
        end
        jsf_pkg::IDX_FRONT_CFG: begin
          next_dat[jsf_pkg::CFG_W-1:0] = front_end_config;
        end
        jsf_pkg::IDX_IRQ_STATUS: begin
          next_dat[jsf_pkg::IRQ_W-1:0] = irq_status;
        end
        jsf_pkg::IDX_IRQ_MASK: begin
          next_dat[jsf_pkg::IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_dat = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // checks on the bus answer
  ack_single_pulse_a: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_one_cycle_a: assert property (@(posedge clk) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  // checks on fullness code
  full_legal_a: assert property (@(posedge clk) disable iff (rst) // see R9
    full_code inside {3'h0, 3'h1, 3'h3, 3'h2, 3'h6})
    else $error("illegal fullness code");

  full_empty_a: assert property (@(posedge clk) disable iff (rst) // see R7
    (fifo_level == '0) |=> (full_code == 3'h0))
    else $error("empty fifo not coded 000");

  full_top_a: assert property (@(posedge clk) disable iff (rst) // see R7
    (lvl4 >= TH3) |=> (full_code == 3'h6))
    else $error("top quarter not coded 110");

  // checks on watermark and quant set
  wm_clear_a: assert property (@(posedge clk) disable iff (rst) // see R2
    wm_clr |=> (wm == $past(cur_q)))
    else $error("watermark not cleared to current level");

  wm_hold_a: assert property (@(posedge clk) disable iff (rst) // see R1
    !wm_clr |=> (wm >= $past(wm)) && (wm >= $past(cur_q)))
    else $error("watermark dropped without clear");

  qset_legal_a: assert property (@(posedge clk) disable iff (rst) // see R3
    qset != 2'h3)
    else $error("reserved quant set reported");

  // checks on the length count
  len_frozen_a: assert property (@(posedge clk) disable iff (rst) // see R6
    (fifo_overflow && !frame_start) ##1 (!frame_start) [*2] |-> $stable(len))
    else $error("length moved after overflow");

  len_count_a: assert property (@(posedge clk) disable iff (rst) // see R5
    (byte_sent && !frozen && !fifo_overflow && !frame_start && len != 24'hFFFFFF)
    |=> (len == $past(len) + 24'h000001))
    else $error("length did not count a sent byte");

  len_high_read_a: assert property (@(posedge clk) disable iff (rst) // see R4
    (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && idx == 6'h02)
    |=> (wb_dat_o[15:8] == $past(len[23:16])))
    else $error("high length byte wrong on read");

  // checks on config and interrupt
  cfg_write_a: assert property (@(posedge clk) disable iff (rst) // see R8
    (wr_now && wb_sel_i[0] && idx == 6'h05)
    |=> (front_end_config == $past(wb_dat_i[5:0])))
    else $error("config write not taken");

  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    irq == |(irq_status & irq_mask))
    else $error("irq not matching masked status");

endmodule // jsf_monitor

// *** testbench/tb.sv ***
// self-checking bench for the encoder status and fifo monitor registers
// assumes jsf_pkg compiled first; fifo depth shrunk to 8 for short quarters
`timescale 1ns/1ps
module tb;
  localparam int D = 8;
  logic        clk, rst, cyc, stb, we, ovf, bsent, fstart, irq, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, q;
  logic [3:0]  lvl;
  logic [1:0]  qsel;
  logic [5:0]  fcfg;
  int          errors, n_checks;

  // device under test
  jsf_monitor #(.DEPTH(D)) u_jsf_monitor (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .fifo_level(lvl),
    .fifo_overflow(ovf), .byte_sent(bsent), .frame_start(fstart), .quant_set_select(qsel),
    .front_end_config(fcfg), .irq(irq));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic wishbone cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= s; dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (ack !== 1'b1) begin
      errors++;
      end_sim();
    end
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [2:0] full_code(input int l);
    if (l == 0) return 3'h0;
    if (4 * l < D) return 3'h1;
    if (4 * l < 2 * D) return 3'h3;
    if (4 * l < 3 * D) return 3'h2;
    return 3'h6;
  endfunction

  // reset values and an unmapped index
  task automatic t_reset();
    wb(0, 6'h09, 0, 4'hF); chk("irq mask", q, 0);
    wb(0, 6'h02, 0, 4'hF); chk("status", q, 0);
    wb(0, 6'h03, 0, 4'hF); chk("len_low", q, 0);
    wb(0, 6'h04, 0, 4'hF); chk("fullness", q, 0);
    wb(0, 6'h05, 0, 4'hF); chk("cfg", q, 0);
    wb(0, 6'h3F, 0, 4'hF); chk("unmapped", q, 0);
  endtask

  // config write, masked write, write to read-only place
  task automatic t_cfg();
    wb(1, 6'h05, 32'h15, 4'h1); wb(0, 6'h05, 0, 4'hF);
    chk("cfg rd", q, 32'h15); chk("cfg port", fcfg, 6'h15);
    wb(1, 6'h05, 32'h00, 4'hE); wb(0, 6'h05, 0, 4'hF); chk("cfg sel", q, 32'h15);
    wb(1, 6'h05, 32'h00, 4'h1); chk("cfg 422", fcfg, 6'h00);
    wb(1, 6'h03, 32'hFFFF, 4'hF); wb(0, 6'h03, 0, 4'hF); chk("len ro", q, 0);
  endtask

  // quant set codes, reserved code keeps previous value
  task automatic t_quant();
    for (int s = 0; s < 4; s++) begin
      qsel <= 2'(s);
      wb(0, 6'h02, 0, 4'hF);
      chk("qset", q[7:6], (s == 3) ? 2'h2 : 2'(s));
    end
  endtask

  // fullness code over every level, irq stays low while masked
  task automatic t_full();
    for (int l = 0; l <= D; l++) begin
      lvl <= 4'(l);
      wb(0, 6'h04, 0, 4'hF);
      chk("full code", q, {29'h0, full_code(l)});
    end
    chk("irq masked", irq, 1'b0);
  endtask

  // watermark hold, clear and interrupt
  task automatic t_wm();
    wb(0, 6'h02, 0, 4'hF); chk("wm top", q[5:4], 2'h3);
    wb(0, 6'h08, 0, 4'hF); chk("wm irq", q[1:0], 2'h2);
    lvl <= 4'h0;
    wb(1, 6'h02, 32'h10, 4'h1); wb(0, 6'h02, 0, 4'hF); chk("wm clr", q[5:4], 2'h0);
    lvl <= 4'h5; wb(0, 6'h02, 0, 4'hF);
    lvl <= 4'h1; wb(0, 6'h02, 0, 4'hF); chk("wm hold", q[5:4], 2'h2);
    wb(1, 6'h09, 32'h2, 4'h1);
    lvl <= 4'h7; wb(0, 6'h02, 0, 4'hF); chk("irq on", irq, 1'b1);
    wb(0, 6'h08, 0, 4'hF); chk("irq st", q[1:0], 2'h2);
    wb(0, 6'h08, 0, 4'hF); chk("irq off", irq, 1'b0);
  endtask

  // length count across 16 bits, freeze on overflow, restart
  task automatic t_len();
    @(posedge clk); fstart <= 1'b1;
    @(posedge clk); fstart <= 1'b0;
    repeat (65538) begin
      @(posedge clk); bsent <= 1'b1;
    end
    @(posedge clk); bsent <= 1'b0;
    wb(0, 6'h02, 0, 4'hF); chk("len hi", q[15:8], 8'h01);
    wb(0, 6'h03, 0, 4'hF); chk("len lo", q, 32'h2);
    wb(1, 6'h09, 32'h1, 4'h1);
    @(posedge clk); ovf <= 1'b1; bsent <= 1'b1;
    @(posedge clk); ovf <= 1'b0;
    repeat (3) @(posedge clk);
    bsent <= 1'b0;
    wb(0, 6'h03, 0, 4'hF); chk("len frozen", q, 32'h2);
    chk("ovf irq", irq, 1'b1);
    wb(0, 6'h08, 0, 4'hF); chk("ovf st", q[0], 1'b1);
    @(posedge clk); fstart <= 1'b1;
    @(posedge clk); fstart <= 1'b0; bsent <= 1'b1;
    @(posedge clk); bsent <= 1'b0;
    wb(0, 6'h03, 0, 4'hF); chk("len restart", q, 32'h1);
  endtask

  // main sequence
  initial begin
    errors = 0; n_checks = 0;
    rst = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; dat = 0;
    lvl = 0; ovf = 0; bsent = 0; fstart = 0; qsel = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_cfg();
    t_quant();
    t_full();
    t_wm();
    t_len();
    end_sim();
  end

  // guard against a hang
  initial begin
    #500000;
    errors++;
    end_sim();
  end
endmodule // tb
